// [verilog/cisl_top.sv]
`timescale 1ns/1ps
// Summary of operation
// - Stage select picks two, mixed, one, none
// - Stage select is write only, reads zero
// - Enable write of one sets mask bit
// - Disable write of one clears mask bit
// - Mask read shows enabled sources as one
// - Mailboxes, states, errors share one layout
// - Busy bits 31 to 29, status only
// - Mailbox event follows ready or abort
// - Error active unless passive or bus off
// - Warning when either counter exceeds 96
// - Passive when either counter reaches 128
// - Bus off when transmit count reaches 256
// - Sleep reads one during low power
// - Wakeup reads one outside low power, resynchronise
// - Timer wrap sets rollover, read clears
// - Busy bits follow receive, transmit and overload activity
// - Timestamp on chosen frame edge, read clears
// - Protocol errors sticky until status read
module cisl_top (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  // Register bus
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Receive line
  input wire logic I_CAN_RX,
  output logic O_RX_SAMPLED,
  // Mailbox flags
  input wire logic [7:0] I_MAILBOX_READY,
  input wire logic [7:0] I_MAILBOX_ABORT,
  // Error counters and protocol events
  input wire logic [8:0] I_TRANSMIT_ERROR_COUNT,
  input wire logic [7:0] I_RECEIVE_ERROR_COUNT,
  input wire cisl_pkg::cisl_proto_type I_PROTO_ERROR,
  // Frame engine state
  input wire logic I_START_OF_FRAME,
  input wire logic I_END_OF_FRAME,
  input wire logic I_RX_BUSY,
  input wire logic I_TX_BUSY,
  input wire logic I_OVERLOAD_BUSY,
  input wire logic I_LOW_POWER_ACTIVE,
  input wire logic [15:0] I_TIMER_VALUE,
  // Controls and interrupt
  output logic O_LOW_POWER_REQ,
  output logic O_FRAME_EDGE_SELECT,
  output logic O_RESYNC_REQ,
  output logic O_IRQ
);

  // ****************************************
  // Declarations
  // ****************************************
  cisl_pkg::cisl_sync_type rx_sync_stage_select;
  cisl_pkg::cisl_conf_type conf;
  logic low_power_enable;
  logic frame_edge_select;
  logic [31:0] irq_enable_state;
  logic [7:0] mailbox_event_flag;
  logic sleep_flag;
  logic low_power_q;
  logic [15:0] timer_q;
  logic timer_rollover_flag;
  logic timestamp_flag;
  cisl_pkg::cisl_proto_type proto_flag;
  logic rx_busy_flag;
  logic tx_busy_flag;
  logic overload_busy_flag;
  logic [31:0] controller_status;
  logic setup;
  logic access;
  logic addr_hit;
  logic wr_mode;
  logic wr_set;
  logic wr_clr;
  logic status_read;
  logic [31:0] read_clear;
  logic [31:0] next_prdata;
  logic timer_wrap;
  logic frame_edge;

  // ****************************************
  // Bus decode
  // ****************************************
  assign setup = I_PSEL && !I_PENABLE;
  assign access = I_PSEL && I_PENABLE;
  assign addr_hit = (I_PADDR == cisl_pkg::ADDR_MODE) || (I_PADDR == cisl_pkg::ADDR_IRQ_SET) ||
                    (I_PADDR == cisl_pkg::ADDR_IRQ_CLR) || (I_PADDR == cisl_pkg::ADDR_IRQ_STATE) ||
                    (I_PADDR == cisl_pkg::ADDR_STATUS);
  assign wr_mode = access && I_PWRITE && (I_PADDR == cisl_pkg::ADDR_MODE);
  assign wr_set = access && I_PWRITE && (I_PADDR == cisl_pkg::ADDR_IRQ_SET);
  assign wr_clr = access && I_PWRITE && (I_PADDR == cisl_pkg::ADDR_IRQ_CLR);
  assign status_read = access && !I_PWRITE && (I_PADDR == cisl_pkg::ADDR_STATUS);
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = access && !addr_hit;

  // Only bits that software actually saw are cleared, so an event landing
  // between the setup and access cycles survives the read.
  assign read_clear = status_read ? (O_PRDATA & cisl_pkg::STICKY_BITS) : 32'h00000000;

  // ****************************************
  // Mode register
  // ****************************************
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      rx_sync_stage_select <= cisl_pkg::SYNC_TWO_RISE;
      low_power_enable <= 1'b0;
      frame_edge_select <= 1'b0;
    end else if (wr_mode) begin
      rx_sync_stage_select <= cisl_pkg::cisl_sync_type'(I_PWDATA[cisl_pkg::MODE_SYNC_MSB:cisl_pkg::MODE_SYNC_LSB]);
      low_power_enable <= I_PWDATA[cisl_pkg::MODE_LPM_BIT];
      frame_edge_select <= I_PWDATA[cisl_pkg::MODE_EDGE_BIT];
    end
  end

  assign O_LOW_POWER_REQ = low_power_enable;
  assign O_FRAME_EDGE_SELECT = frame_edge_select;

  // ****************************************
  // Interrupt mask
  // ****************************************
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      irq_enable_state <= cisl_pkg::MASK_RESET;
    end else if (wr_set) begin
      irq_enable_state <= irq_enable_state | (I_PWDATA & cisl_pkg::IRQ_VALID_BITS);
    end else if (wr_clr) begin
      irq_enable_state <= irq_enable_state & ~(I_PWDATA & cisl_pkg::IRQ_VALID_BITS);
    end
  end

  // ****************************************
  // Event sources
  // ****************************************
  generate
    for (genvar mb = 0; mb < 8; mb++) begin : g_mailbox
      always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
          mailbox_event_flag[mb] <= 1'b0;
        end else begin
          mailbox_event_flag[mb] <= I_MAILBOX_READY[mb] || I_MAILBOX_ABORT[mb];
        end
      end
    end
  endgenerate

  assign timer_wrap = (timer_q == cisl_pkg::TIMER_TOP) && (I_TIMER_VALUE == cisl_pkg::TIMER_ZERO);
  assign frame_edge = frame_edge_select ? I_END_OF_FRAME : I_START_OF_FRAME;

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      timer_q <= cisl_pkg::TIMER_ZERO;
      timer_rollover_flag <= 1'b0;
      timestamp_flag <= 1'b0;
      proto_flag <= 5'h00;
    end else begin
      timer_q <= I_TIMER_VALUE;
      timer_rollover_flag <= (timer_rollover_flag && !read_clear[cisl_pkg::ST_TIMER_ROLLOVER_FLAG]) || timer_wrap;
      timestamp_flag <= (timestamp_flag && !read_clear[cisl_pkg::ST_TIMESTAMP_FLAG]) || frame_edge;
      proto_flag <= (proto_flag & ~read_clear[cisl_pkg::ST_PROTO_MSB:cisl_pkg::ST_PROTO_LSB]) |
                    I_PROTO_ERROR;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      sleep_flag <= 1'b0;
      low_power_q <= 1'b0;
      O_RESYNC_REQ <= 1'b0;
    end else begin
      sleep_flag <= I_LOW_POWER_ACTIVE;
      low_power_q <= I_LOW_POWER_ACTIVE;
      O_RESYNC_REQ <= low_power_q && !I_LOW_POWER_ACTIVE;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      rx_busy_flag <= 1'b0;
      tx_busy_flag <= 1'b0;
      overload_busy_flag <= 1'b0;
    end else begin
      rx_busy_flag <= I_RX_BUSY;
      tx_busy_flag <= I_TX_BUSY;
      overload_busy_flag <= I_OVERLOAD_BUSY;
    end
  end

  cisl_error_state u_error_state (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RST_N),
    .i_tec(I_TRANSMIT_ERROR_COUNT),
    .i_rec(I_RECEIVE_ERROR_COUNT),
    .o_conf(conf)
  );

  cisl_rx_sync u_rx_sync (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RST_N),
    .i_rx(I_CAN_RX),
    .i_sel(rx_sync_stage_select),
    .o_rx(O_RX_SAMPLED)
  );

  // ****************************************
  // Status word and read data
  // ****************************************
  always_comb begin
    controller_status = 32'h00000000;
    controller_status[cisl_pkg::ST_MB_MSB:cisl_pkg::ST_MB_LSB] = mailbox_event_flag;
    controller_status[cisl_pkg::ST_CONF_MSB:cisl_pkg::ST_CONF_LSB] = conf;
    controller_status[cisl_pkg::ST_SLEEP] = sleep_flag;
    controller_status[cisl_pkg::ST_WAKEUP] = !sleep_flag;
    controller_status[cisl_pkg::ST_TIMER_ROLLOVER_FLAG] = timer_rollover_flag;
    controller_status[cisl_pkg::ST_TIMESTAMP_FLAG] = timestamp_flag;
    controller_status[cisl_pkg::ST_PROTO_MSB:cisl_pkg::ST_PROTO_LSB] = proto_flag;
    controller_status[cisl_pkg::ST_RX_BUSY_FLAG] = rx_busy_flag;
    controller_status[cisl_pkg::ST_TX_BUSY_FLAG] = tx_busy_flag;
    controller_status[cisl_pkg::ST_OVERLOAD_BUSY_FLAG] = overload_busy_flag;
  end

  always_comb begin
    next_prdata = 32'h00000000;
    case (I_PADDR)
      cisl_pkg::ADDR_MODE: begin
        // The stage select stays hidden; it is a debug knob only.
        next_prdata[cisl_pkg::MODE_LPM_BIT] = low_power_enable;
        next_prdata[cisl_pkg::MODE_EDGE_BIT] = frame_edge_select;
      end
      cisl_pkg::ADDR_IRQ_STATE: next_prdata = irq_enable_state;
      cisl_pkg::ADDR_STATUS: next_prdata = controller_status;
      default: next_prdata = 32'h00000000;
    endcase
  end

  // Read data is captured in the setup cycle so the access cycle answers at once.
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      O_PRDATA <= 32'h00000000;
    end else if (setup && !I_PWRITE) begin
      O_PRDATA <= next_prdata;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= |(controller_status & irq_enable_state);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);

  property p_sync_two;
    (rx_sync_stage_select == cisl_pkg::SYNC_TWO_RISE) && $past(I_RST_N, 2) && $past(I_RST_N) |->
      O_RX_SAMPLED == $past(I_CAN_RX, 2);
  endproperty
  a_sync_two: assert property (p_sync_two) else $error("two stage sync latency wrong");

  property p_sync_bypass;
    (rx_sync_stage_select == cisl_pkg::SYNC_BYPASS) |-> O_RX_SAMPLED == I_CAN_RX;
  endproperty
  a_sync_bypass: assert property (p_sync_bypass) else $error("bypass not transparent");

  property p_mode_hidden;
    setup && !I_PWRITE && (I_PADDR == cisl_pkg::ADDR_MODE) |=> O_PRDATA[25:24] == 2'h0;
  endproperty
  a_mode_hidden: assert property (p_mode_hidden) else $error("stage select readable");

  property p_mask_set;
    wr_set |=> ((irq_enable_state & $past(I_PWDATA) & cisl_pkg::IRQ_VALID_BITS) ==
                ($past(I_PWDATA) & cisl_pkg::IRQ_VALID_BITS))
               && ((irq_enable_state | $past(irq_enable_state)) == irq_enable_state);
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("enable write failed");

  property p_mask_clr;
    wr_clr |=> (irq_enable_state & $past(I_PWDATA)) == 32'h00000000 &&
               ((irq_enable_state & ~$past(irq_enable_state)) == 32'h00000000);
  endproperty
  a_mask_clr: assert property (p_mask_clr) else $error("disable write failed");

  property p_mask_read;
    setup && !I_PWRITE && (I_PADDR == cisl_pkg::ADDR_IRQ_STATE) ##1 access |-> O_PRDATA == irq_enable_state;
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask read mismatch");

  property p_busy_bits;
    (irq_enable_state[31:29] == 3'h0) ##1 (controller_status[31:29] == $past({I_OVERLOAD_BUSY, I_TX_BUSY, I_RX_BUSY}));
  endproperty
  a_busy_bits: assert property (p_busy_bits) else $error("busy bits wrong");

  property p_mailbox;
    (I_MAILBOX_READY[0] || I_MAILBOX_ABORT[0]) |=> controller_status[0];
  endproperty
  a_mailbox: assert property (p_mailbox) else $error("mailbox event missed");

  property p_warn;
    (I_TRANSMIT_ERROR_COUNT > 9'd96) |=> controller_status[17];
  endproperty
  a_warn: assert property (p_warn) else $error("warning not raised");

  property p_bus_off_flag;
    (I_TRANSMIT_ERROR_COUNT >= 9'd256) |=> controller_status[19] && !controller_status[16];
  endproperty
  a_bus_off_flag: assert property (p_bus_off_flag) else $error("bus off wrong");

  property p_timer_rollover_flag;
    timer_wrap |=> timer_rollover_flag;
  endproperty
  a_timer_rollover_flag: assert property (p_timer_rollover_flag) else $error("rollover missed");

  property p_wake;
    $fell(I_LOW_POWER_ACTIVE) |=> O_RESYNC_REQ ##1 controller_status[21];
  endproperty
  a_wake: assert property (p_wake) else $error("wake handling wrong");

  property p_irq;
    |(controller_status & irq_enable_state) |=> O_IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  c_irq: cover property ($rose(O_IRQ));
  c_timer_rollover_flag_clear: cover property (timer_rollover_flag ##1 status_read ##1 !timer_rollover_flag);
  c_passive: cover property ($rose(controller_status[18]));

endmodule

// [pkg/cisl_pkg.sv]
package cisl_pkg;

  // ****************************************
  // Register offsets, byte addresses
  // ****************************************
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_IRQ_SET = 8'h04;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATE = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // ****************************************
  // Mode register fields
  // ****************************************
  localparam int MODE_LPM_BIT = 1;
  localparam int MODE_EDGE_BIT = 4;
  localparam int MODE_SYNC_LSB = 24;
  localparam int MODE_SYNC_MSB = 25;

  // ****************************************
  // Shared interrupt and status layout
  // ****************************************
  localparam int ST_MB_LSB = 0;
  localparam int ST_MB_MSB = 7;
  localparam int ST_CONF_LSB = 16;
  localparam int ST_CONF_MSB = 19;
  localparam int ST_SLEEP = 20;
  localparam int ST_WAKEUP = 21;
  localparam int ST_TIMER_ROLLOVER_FLAG = 22;
  localparam int ST_TIMESTAMP_FLAG = 23;
  localparam int ST_PROTO_LSB = 24;
  localparam int ST_PROTO_MSB = 28;
  localparam int ST_RX_BUSY_FLAG = 29;
  localparam int ST_TX_BUSY_FLAG = 30;
  localparam int ST_OVERLOAD_BUSY_FLAG = 31;
  localparam logic [31:0] IRQ_VALID_BITS = 32'h1fff00ff;
  localparam logic [31:0] MASK_RESET = 32'h00000000;
  localparam logic [31:0] STICKY_BITS = 32'h1fc00000;

  // ****************************************
  // Fault confinement limits and timer
  // ****************************************
  localparam logic [8:0] WARN_LIMIT = 9'h060;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h080;
  localparam logic [8:0] BUS_OFF_LIMIT = 9'h100;
  localparam logic [15:0] TIMER_TOP = 16'hffff;
  localparam logic [15:0] TIMER_ZERO = 16'h0000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    SYNC_TWO_RISE = 2'h0,
    SYNC_RISE_FALL = 2'h1,
    SYNC_ONE_RISE = 2'h2,
    SYNC_BYPASS = 2'h3
  } cisl_sync_type;

  typedef struct packed {
    logic bit_error_flag;
    logic form_error_flag;
    logic ack_error_flag;
    logic stuffing_error_flag;
    logic crc_error_flag;
  } cisl_proto_type;

  typedef struct packed {
    logic bus_off_flag;
    logic error_passive_flag;
    logic warning_flag;
    logic error_active_flag;
  } cisl_conf_type;

endpackage

// [verilog/cisl_rx_sync.sv]
`timescale 1ns/1ps
module cisl_rx_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Receive line and stage choice
  input wire logic i_rx,
  input wire cisl_pkg::cisl_sync_type i_sel,
  // Sampled line
  output logic o_rx
);

  logic two_a;
  logic two_b;
  logic mix_a;
  logic mix_b;
  logic one_a;

  // The line idles recessive, so every stage resets high.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      two_a <= 1'b1;
      two_b <= 1'b1;
      mix_a <= 1'b1;
      one_a <= 1'b1;
    end else begin
      two_a <= i_rx;
      two_b <= two_a;
      mix_a <= i_rx;
      one_a <= i_rx;
    end
  end

  // Half a cycle of latency is traded for a shorter settling margin.
  always_ff @(negedge i_clk) begin
    if (!i_rst_n) begin
      mix_b <= 1'b1;
    end else begin
      mix_b <= mix_a;
    end
  end

  always_comb begin
    case (i_sel)
      cisl_pkg::SYNC_TWO_RISE: o_rx = two_b;
      cisl_pkg::SYNC_RISE_FALL: o_rx = mix_b;
      cisl_pkg::SYNC_ONE_RISE: o_rx = one_a;
      default: o_rx = i_rx;
    endcase
  end

endmodule

// [verilog/cisl_error_state.sv]
`timescale 1ns/1ps
module cisl_error_state (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Error counters
  input wire logic [8:0] i_tec,
  input wire logic [7:0] i_rec,
  // Confinement state
  output cisl_pkg::cisl_conf_type o_conf
);

  logic [8:0] rec_wide;
  cisl_pkg::cisl_conf_type next_conf;

  assign rec_wide = {1'b0, i_rec};

  always_comb begin
    next_conf.warning_flag = (i_tec > cisl_pkg::WARN_LIMIT) || (rec_wide > cisl_pkg::WARN_LIMIT);
    next_conf.error_passive_flag = (i_tec >= cisl_pkg::PASSIVE_LIMIT) ||
                                   (rec_wide >= cisl_pkg::PASSIVE_LIMIT);
    next_conf.bus_off_flag = i_tec >= cisl_pkg::BUS_OFF_LIMIT;
    next_conf.error_active_flag = !(next_conf.error_passive_flag || next_conf.bus_off_flag);
  end

  // Levels follow the counters, so nothing here is sticky.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_conf <= 4'h1;
    end else begin
      o_conf <= next_conf;
    end
  end

endmodule

// [tb/cisl_can_node.sv]
`timescale 1ns/1ps
module cisl_can_node #(
  parameter int BIT_CYCLES = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Frame request
  input wire logic i_start,
  input wire logic [7:0] i_bits,
  // Bus side view
  output logic o_rx,
  output logic o_sof,
  output logic o_eof,
  output logic o_busy
);
  // ****************************************
  // Frame sender
  // ****************************************
  // The line rests recessive between frames, so a stale dominant bit never lingers.
  logic [7:0] shift;
  logic [3:0] idx;
  int cnt;
  always_ff @(posedge i_clk) begin
    o_sof <= 1'b0;
    o_eof <= 1'b0;
    if (!i_rst_n) begin
      o_rx <= 1'b1;
      o_busy <= 1'b0;
      idx <= 4'h0;
      cnt <= 0;
      shift <= 8'hff;
    end else if (!o_busy) begin
      if (i_start) begin
        o_busy <= 1'b1;
        o_sof <= 1'b1;
        o_rx <= i_bits[7];
        shift <= {i_bits[6:0], 1'b1};
        idx <= 4'h0;
        cnt <= 0;
      end
    end else if (cnt == BIT_CYCLES - 1) begin
      cnt <= 0;
      if (idx == 4'h7) begin
        o_busy <= 1'b0;
        o_eof <= 1'b1;
        o_rx <= 1'b1;
      end else begin
        idx <= idx + 4'h1;
        o_rx <= shift[7];
        shift <= {shift[6:0], 1'b1};
      end
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// [tb/cisl_top_tb_top.sv]
`timescale 1ns/1ps
module cisl_top_tb_top;
  // ****************************************
  // Signals
  // ****************************************
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, can_rx, rx_samp, start;
  logic [7:0] paddr, mb_rdy, mb_abt, receive_error_count, bits;
  logic [31:0] pwdata, prdata;
  logic [8:0] transmit_error_count;
  cisl_pkg::cisl_proto_type proto;
  logic sof, eof, rx_busy, tx_busy, ovl_busy, lpa, lp_req, edge_sel, resync, irq;
  logic [15:0] timer;
  int error_cnt = 0;
  int n_compared = 0;
  logic [8:0] tec_tab [10] = '{9'h000, 9'h060, 9'h061, 9'h000, 9'h07f, 9'h080, 9'h000, 9'h0ff, 9'h100, 9'h1ff};
  logic [7:0] rec_tab [10] = '{8'h00, 8'h60, 8'h00, 8'h61, 8'h00, 8'h00, 8'h80, 8'h7f, 8'h00, 8'hff};
  logic [3:0] conf_tab [10] = '{4'h1, 4'h1, 4'h3, 4'h3, 4'h3, 4'h6, 4'h6, 4'h6, 4'he, 4'he};

  cisl_top u_dut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_CAN_RX(can_rx), .O_RX_SAMPLED(rx_samp), .I_MAILBOX_READY(mb_rdy), .I_MAILBOX_ABORT(mb_abt),
    .I_TRANSMIT_ERROR_COUNT(transmit_error_count), .I_RECEIVE_ERROR_COUNT(receive_error_count), .I_PROTO_ERROR(proto),
    .I_START_OF_FRAME(sof), .I_END_OF_FRAME(eof), .I_RX_BUSY(rx_busy), .I_TX_BUSY(tx_busy),
    .I_OVERLOAD_BUSY(ovl_busy), .I_LOW_POWER_ACTIVE(lpa), .I_TIMER_VALUE(timer), .O_LOW_POWER_REQ(lp_req),
    .O_FRAME_EDGE_SELECT(edge_sel), .O_RESYNC_REQ(resync), .O_IRQ(irq));
  cisl_can_node u_node (.i_clk(clk), .i_rst_n(rst_n), .i_start(start), .i_bits(bits), .o_rx(can_rx),
    .o_sof(sof), .o_eof(eof), .o_busy(rx_busy));

  // ****************************************
  // Clock and helpers
  // ****************************************
  // The clock never stops, so a wake event can always be seen.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task finish_test();
    if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
      error_cnt++;
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] ex);
    logic [31:0] q;
    logic e;
    xfer(1'b0, a, 32'h0, q, e);
    chk(nm, ex, q & m);
  endtask
  task frame();
    @(posedge clk);
    start <= 1'b1;
    bits <= 8'h00;
    @(posedge clk);
    start <= 1'b0;
  endtask
  task wait_idle();
    while (rx_busy !== 1'b0) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset();
    logic [31:0] q;
    logic e;
    rdc("mask_reset", cisl_pkg::ADDR_IRQ_STATE, 32'hffffffff, 32'h0);
    rdc("status_reset", cisl_pkg::ADDR_STATUS, 32'hffffffff, 32'h00210000);
    rdc("mode_reset", cisl_pkg::ADDR_MODE, 32'hffffffff, 32'h0);
    xfer(1'b0, 8'h20, 32'h0, q, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, q);
    chk("outputs_reset", 32'h0, {29'h0, lp_req, edge_sel, irq});
  endtask
  task t_mask();
    wr(cisl_pkg::ADDR_IRQ_SET, 32'hffffffff);
    rdc("mask_all", cisl_pkg::ADDR_IRQ_STATE, 32'hffffffff, cisl_pkg::IRQ_VALID_BITS);
    chk("irq_active", 32'h1, {31'h0, irq});
    wr(cisl_pkg::ADDR_IRQ_SET, 32'h0);
    wr(cisl_pkg::ADDR_IRQ_CLR, 32'h000000f0);
    rdc("mask_clr", cisl_pkg::ADDR_IRQ_STATE, 32'hffffffff, 32'h1fff000f);
    wr(cisl_pkg::ADDR_IRQ_STATE, 32'h0);
    rdc("mask_ro", cisl_pkg::ADDR_IRQ_STATE, 32'hffffffff, 32'h1fff000f);
    rdc("set_wo", cisl_pkg::ADDR_IRQ_SET, 32'hffffffff, 32'h0);
    wr(cisl_pkg::ADDR_IRQ_CLR, 32'hffffffff);
    repeat (3) @(posedge clk);
    chk("irq_none", 32'h0, {31'h0, irq});
  endtask
  task t_conf();
    logic [31:0] ex;
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      transmit_error_count <= tec_tab[i];
      receive_error_count <= rec_tab[i];
      ex = {12'h0, conf_tab[i], 16'h0};
      repeat (4) @(posedge clk);
      rdc("conf", cisl_pkg::ADDR_STATUS, 32'h000f0000, ex);
    end
    transmit_error_count <= 9'h0;
    receive_error_count <= 8'h0;
  endtask
  task t_mbox();
    mb_rdy <= 8'h08;
    mb_abt <= 8'h40;
    repeat (3) @(posedge clk);
    rdc("mailbox", cisl_pkg::ADDR_STATUS, 32'h000000ff, 32'h48);
    wr(cisl_pkg::ADDR_IRQ_SET, 32'h08);
    repeat (3) @(posedge clk);
    chk("irq_mb", 32'h1, {31'h0, irq});
    wr(cisl_pkg::ADDR_IRQ_CLR, 32'h08);
    repeat (3) @(posedge clk);
    chk("irq_mb_off", 32'h0, {31'h0, irq});
    mb_rdy <= 8'h0;
    mb_abt <= 8'h0;
    repeat (3) @(posedge clk);
    rdc("mailbox_idle", cisl_pkg::ADDR_STATUS, 32'h000000ff, 32'h0);
  endtask
  task t_sticky();
    rdc("clear", cisl_pkg::ADDR_STATUS, 32'h0, 32'h0);
    for (int i = 0; i < 5; i++) begin
      proto <= cisl_pkg::cisl_proto_type'(5'h01 << i);
      @(posedge clk);
      proto <= '0;
      repeat (2) @(posedge clk);
      rdc("proto_set", cisl_pkg::ADDR_STATUS, 32'h1f000000, 32'h01000000 << i);
      rdc("proto_clr", cisl_pkg::ADDR_STATUS, 32'h1f000000, 32'h0);
    end
    timer <= 16'hffff;
    @(posedge clk);
    timer <= 16'h0000;
    repeat (2) @(posedge clk);
    rdc("timer_rollover_flag_set", cisl_pkg::ADDR_STATUS, 32'h00400000, 32'h00400000);
    rdc("timer_rollover_flag_clr", cisl_pkg::ADDR_STATUS, 32'h00400000, 32'h0);
    wr(cisl_pkg::ADDR_IRQ_SET, 32'h04000000);
    proto <= cisl_pkg::cisl_proto_type'(5'h04);
    @(posedge clk);
    proto <= '0;
    repeat (3) @(posedge clk);
    chk("irq_ack", 32'h1, {31'h0, irq});
    rdc("ack_read", cisl_pkg::ADDR_STATUS, 32'h0, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq_ack_off", 32'h0, {31'h0, irq});
    wr(cisl_pkg::ADDR_IRQ_CLR, 32'hffffffff);
  endtask
  task t_frame();
    rdc("clear", cisl_pkg::ADDR_STATUS, 32'h0, 32'h0);
    tx_busy <= 1'b1;
    ovl_busy <= 1'b1;
    frame();
    repeat (5) @(posedge clk);
    rdc("sof_busy", cisl_pkg::ADDR_STATUS, 32'he0800000, 32'he0800000);
    rdc("timestamp_flag_clr", cisl_pkg::ADDR_STATUS, 32'h00800000, 32'h0);
    tx_busy <= 1'b0;
    ovl_busy <= 1'b0;
    wait_idle();
    rdc("eof_idle", cisl_pkg::ADDR_STATUS, 32'he0800000, 32'h0);
    wr(cisl_pkg::ADDR_MODE, 32'h00000010);
    @(posedge clk);
    chk("edge_sel", 32'h1, {31'h0, edge_sel});
    frame();
    repeat (5) @(posedge clk);
    rdc("sof_ignored", cisl_pkg::ADDR_STATUS, 32'h00800000, 32'h0);
    wait_idle();
    rdc("eof_timestamp_flag", cisl_pkg::ADDR_STATUS, 32'h00800000, 32'h00800000);
    wr(cisl_pkg::ADDR_MODE, 32'h0);
  endtask
  task t_sync();
    int lat;
    for (int s = 0; s < 4; s++) begin
      wr(cisl_pkg::ADDR_MODE, 32'(s) << cisl_pkg::MODE_SYNC_LSB);
      rdc("sync_read", cisl_pkg::ADDR_MODE, 32'hffffffff, 32'h0);
      lat = (s == 3) ? 0 : (s == 2) ? 2 : (s == 1) ? 3 : 4;
      frame();
      for (int k = 0; k < 5; k++) begin
        if (k % 2 == 1) @(negedge clk);
        else if (k > 0) @(posedge clk);
        #1;
        chk("rx_stage", (k >= lat) ? 32'h0 : 32'h1, {31'h0, rx_samp});
      end
      wait_idle();
    end
    wr(cisl_pkg::ADDR_MODE, 32'h0);
  endtask
  task t_lowpower();
    int hits;
    int at;
    hits = 0;
    at = 0;
    wr(cisl_pkg::ADDR_MODE, 32'h00000002);
    @(posedge clk);
    chk("lp_req", 32'h1, {31'h0, lp_req});
    lpa <= 1'b1;
    repeat (3) @(posedge clk);
    rdc("sleep", cisl_pkg::ADDR_STATUS, 32'h00300000, 32'h00100000);
    @(posedge clk);
    lpa <= 1'b0;
    for (int k = 1; k < 7; k++) begin
      @(posedge clk);
      #1;
      if (resync === 1'b1) begin
        hits++;
        at = k;
      end
    end
    chk("resync_cnt", 32'h1, 32'(hits));
    chk("resync_at", 32'h1, 32'(at));
    rdc("awake", cisl_pkg::ADDR_STATUS, 32'h00300000, 32'h00200000);
    wr(cisl_pkg::ADDR_MODE, 32'h0);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, start, tx_busy, ovl_busy, lpa} = 7'h0;
    {paddr, mb_rdy, mb_abt, receive_error_count, bits} = 40'h0;
    pwdata = 32'h0;
    transmit_error_count = 9'h0;
    proto = '0;
    timer = 16'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_mask();
    t_conf();
    t_mbox();
    t_sticky();
    t_frame();
    t_sync();
    t_lowpower();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
endmodule
